// ### ircfg_consts.svh
`ifndef IRCFG_CONSTS_SVH
`define IRCFG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define IRCFG_DEVCTL_OFS 8'h92
`define IRCFG_DIAG_OFS 8'h93
`define IRCFG_DEVCTL_RST 8'h66
`define IRCFG_DIAG_RST 8'h61
`define IRCFG_DEVCTL_WMASK 8'hEF
`define IRCFG_SHARED_MASK 8'h4F

// ----------------------------------------------------------------
// Field positions, device control
// ----------------------------------------------------------------
`define IRCFG_DC_HOLD 7
`define IRCFG_DC_LVFORCE 6
`define IRCFG_DC_IODIAG 5
`define IRCFG_DC_TEST 3
`define IRCFG_DC_MODE_HI 2
`define IRCFG_DC_MODE_LO 1
`define IRCFG_DC_NAND 0

// ----------------------------------------------------------------
// Field positions, diagnostic control
// ----------------------------------------------------------------
`define IRCFG_DG_IDMASK 7
`define IRCFG_DG_ROUTE 5
`define IRCFG_DG_NODT 4
`define IRCFG_DG_RETRY 3
`define IRCFG_DG_CARDDT 2
`define IRCFG_DG_HOSTDT 1
`define IRCFG_DG_ASYNC 0

// ----------------------------------------------------------------
// Timing counts, in clocks
// ----------------------------------------------------------------
`define IRCFG_RETRY_BASE 7'h10
`define IRCFG_RETRY_LONG 7'h40
`define IRCFG_DISCARD_SHORT 16'h0400
`define IRCFG_DISCARD_LONG 32768
`define IRCFG_INTERROG_FULL 65536
`define IRCFG_INTERROG_SHORT 16

`endif

// ### ircfg_pkg.sv
package ircfg_pkg;
  typedef enum logic [1:0] {
    irq_par_only = 2'h0,
    irq_reserved = 2'h1,
    irq_ser_par = 2'h2,
    irq_ser_all = 2'h3
  } ircfg_irq_mode_t;
endpackage

// ### ircfg_regs.sv
`timescale 1ns/1ps
`include "ircfg_consts.svh"
// Summary of operation
// - Hold bit set blocks software socket power-down while in D3.
// - Bit 6 forces reported low-voltage socket capability; resets to 1.
// - Bit 5 is a read/write diagnostic flag resetting to 1.
// - Bit 4 of device control reads zero; writes ignored.
// - Test bit shortens the interrogation counter; software writes zero.
// - Bits 2-1 select interrupt signalling; 11 after reset.
// - Shared bits 6 and 3-0 are changed only through function 0.
// - Bit 0 enables a NAND tree over input and bidirectional pins.
// - Identity mask bit makes identity reads return all ones.
// - Bit 5 picks card-change routing: legacy enable or select 0000b.
// - Diagnostic bit 4 disables delayed transactions.
// - Diagnostic bit 3 extends retry latency from 16 to 64.
// - Diagnostic bit 2 picks card-side discard timer, 2^10 or 2^15.
// - Diagnostic bit 1 picks host-side discard timer, 2^10 or 2^15.
// - Diagnostic bit 0 enables asynchronous card-change interrupt.
module ircfg_regs
  import ircfg_pkg::*;
#(
  parameter int NAND_PINS = 8,
  parameter int DISCARD_LONG = `IRCFG_DISCARD_LONG,
  parameter int INTERROG_FULL = `IRCFG_INTERROG_FULL,
  parameter int INTERROG_SHORT = `IRCFG_INTERROG_SHORT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [31:0] id_true_value,
  output logic [31:0] id_read_value,
  input wire logic sw_pwr_down_req,
  input wire logic in_d3,
  output logic socket_pwr_down,
  output logic low_volt_socket_force,
  output logic io_diag_flag,
  output logic irq_par_en,
  output logic irq_serial_en,
  output logic irq_ser_pci_en,
  output logic interrog_tick,
  output logic nand_tree_en,
  input wire logic [NAND_PINS-1:0] nand_pins,
  output logic nand_tree_out,
  input wire logic chg_legacy_en,
  input wire logic [3:0] chg_irq_sel,
  input wire logic card_chg_event,
  output logic card_change_route,
  output logic async_change_irq,
  output logic delayed_txn_off,
  output logic [6:0] retry_limit,
  input wire logic [1:0] dt_start,
  input wire logic [1:0] dt_clear,
  output logic [1:0] dt_expired
);

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic [7:0] devctl_reg;
  logic [7:0] devctl_next;
  logic [7:0] diag_reg;
  logic [7:0] diag_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  wire hit_devctl = cfg_addr == `IRCFG_DEVCTL_OFS;
  wire hit_diag = cfg_addr == `IRCFG_DIAG_OFS;

  // Function 1 may not touch the shared bits
  wire [7:0] devctl_wmask = cfg_func ?
    (`IRCFG_DEVCTL_WMASK & ~`IRCFG_SHARED_MASK) : `IRCFG_DEVCTL_WMASK;
  assign devctl_next = (cfg_wr && hit_devctl) ?
    ((devctl_reg & ~devctl_wmask) | (cfg_wdata & devctl_wmask)) :
    devctl_reg;
  assign diag_next = (cfg_wr && hit_diag) ? cfg_wdata : diag_reg;
  wire [7:0] rd_mux = hit_devctl ? devctl_reg :
                      hit_diag ? diag_reg : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      devctl_reg <= `IRCFG_DEVCTL_RST;
      diag_reg <= `IRCFG_DIAG_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      devctl_reg <= devctl_next;
      diag_reg <= diag_next;
      rdata_reg <= cfg_rd ? rd_mux : rdata_reg;
      rvalid_reg <= cfg_rd;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Device control fields
  // ----------------------------------------------------------------
  ircfg_irq_mode_t irq_mode;
  assign irq_mode = ircfg_irq_mode_t'(
    devctl_reg[`IRCFG_DC_MODE_HI:`IRCFG_DC_MODE_LO]);
  assign low_volt_socket_force = devctl_reg[`IRCFG_DC_LVFORCE];
  assign io_diag_flag = devctl_reg[`IRCFG_DC_IODIAG];
  assign nand_tree_en = devctl_reg[`IRCFG_DC_NAND];

  // Reserved mode code enables nothing rather than guessing a mix
  assign irq_par_en = (irq_mode == irq_par_only) ||
                      (irq_mode == irq_ser_par);
  assign irq_serial_en = (irq_mode == irq_ser_par) ||
                         (irq_mode == irq_ser_all);
  assign irq_ser_pci_en = irq_mode == irq_ser_all;

  // ----------------------------------------------------------------
  // Socket power gating
  // ----------------------------------------------------------------
  logic pwr_down_reg;
  wire pwr_block = devctl_reg[`IRCFG_DC_HOLD] && in_d3;
  wire pwr_down_next = sw_pwr_down_req && !pwr_block;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_down_reg <= 1'b0;
    end else begin
      pwr_down_reg <= pwr_down_next;
    end
  end

  assign socket_pwr_down = pwr_down_reg;

  // ----------------------------------------------------------------
  // Interrogation counter
  // ----------------------------------------------------------------
  logic [16:0] interrog_cnt_reg;
  logic interrog_tick_reg;
  wire [16:0] interrog_last = devctl_reg[`IRCFG_DC_TEST] ?
    17'(INTERROG_SHORT - 1) : 17'(INTERROG_FULL - 1);
  // Compare with >= so a switch to the short period never overshoots
  wire interrog_wrap = interrog_cnt_reg >= interrog_last;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrog_cnt_reg <= 17'h00000;
      interrog_tick_reg <= 1'b0;
    end else begin
      interrog_cnt_reg <= interrog_wrap ? 17'h00000 :
                          interrog_cnt_reg + 17'h00001;
      interrog_tick_reg <= interrog_wrap;
    end
  end

  assign interrog_tick = interrog_tick_reg;

  // ----------------------------------------------------------------
  // NAND tree over input and bidirectional pins only
  // ----------------------------------------------------------------
  logic [NAND_PINS-1:0] nand_meta_reg;
  logic [NAND_PINS-1:0] nand_sync_reg;
  logic nand_out_reg;
  wire [NAND_PINS:0] nand_chain;
  assign nand_chain[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < NAND_PINS; gi++) begin : g_nand
      assign nand_chain[gi+1] = ~(nand_chain[gi] & nand_sync_reg[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nand_meta_reg <= '0;
      nand_sync_reg <= '0;
      nand_out_reg <= 1'b0;
    end else begin
      nand_meta_reg <= nand_pins;
      nand_sync_reg <= nand_meta_reg;
      nand_out_reg <= nand_tree_en && nand_chain[NAND_PINS];
    end
  end

  assign nand_tree_out = nand_out_reg;

  // ----------------------------------------------------------------
  // Identity readback and card-change routing
  // ----------------------------------------------------------------
  logic [31:0] id_value_reg;
  logic async_irq_reg;
  wire route_by_sel = diag_reg[`IRCFG_DG_ROUTE];
  assign card_change_route = route_by_sel ?
    (chg_irq_sel == 4'h0) : chg_legacy_en;
  wire async_irq_next = card_chg_event && card_change_route &&
                        diag_reg[`IRCFG_DG_ASYNC];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_value_reg <= 32'h00000000;
      async_irq_reg <= 1'b0;
    end else begin
      id_value_reg <= diag_reg[`IRCFG_DG_IDMASK] ?
        32'hFFFFFFFF : id_true_value;
      async_irq_reg <= async_irq_next;
    end
  end

  assign id_read_value = id_value_reg;
  assign async_change_irq = async_irq_reg;

  // ----------------------------------------------------------------
  // Delayed transaction and retry controls
  // ----------------------------------------------------------------
  assign delayed_txn_off = diag_reg[`IRCFG_DG_NODT];
  assign retry_limit = diag_reg[`IRCFG_DG_RETRY] ?
    `IRCFG_RETRY_LONG : `IRCFG_RETRY_BASE;

  // ----------------------------------------------------------------
  // Discard timers: index 0 host side, index 1 card side
  // ----------------------------------------------------------------
  wire [1:0] dt_short_sel = {diag_reg[`IRCFG_DG_CARDDT],
                             diag_reg[`IRCFG_DG_HOSTDT]};
  logic [15:0] dt_cnt_reg [2];
  logic dt_run_reg [2];
  logic dt_exp_reg [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_dt
      wire [15:0] dt_last = dt_short_sel[gi] ?
        (`IRCFG_DISCARD_SHORT - 16'h0001) :
        16'(DISCARD_LONG - 1);
      wire dt_done = dt_run_reg[gi] && dt_cnt_reg[gi] == dt_last;
      // A late start restarts the count; clear wins only if no start
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dt_cnt_reg[gi] <= 16'h0000;
          dt_run_reg[gi] <= 1'b0;
          dt_exp_reg[gi] <= 1'b0;
        end else begin
          dt_cnt_reg[gi] <= (dt_start[gi] || !dt_run_reg[gi]) ?
            16'h0000 : dt_cnt_reg[gi] + 16'h0001;
          dt_run_reg[gi] <= dt_start[gi] ||
            (dt_run_reg[gi] && !dt_clear[gi] && !dt_done);
          dt_exp_reg[gi] <= dt_done && !dt_start[gi] && !dt_clear[gi];
        end
      end
    end
  endgenerate

  assign dt_expired = {dt_exp_reg[1], dt_exp_reg[0]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reserved_bit_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    devctl_reg[4] == 1'b0)
    else $error("reserved device control bit set");

  a_func1_shared_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && cfg_func && hit_devctl |=>
    (devctl_reg & `IRCFG_SHARED_MASK) ==
    ($past(devctl_reg) & `IRCFG_SHARED_MASK))
    else $error("function 1 changed a shared bit");

  a_power_hold_d3: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    devctl_reg[`IRCFG_DC_HOLD] && in_d3 |=> !socket_pwr_down)
    else $error("socket powered down while held in D3");

  a_power_pass: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sw_pwr_down_req && !in_d3 |=> socket_pwr_down)
    else $error("power-down request lost");

  a_irq_mode_map: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    irq_ser_pci_en |-> irq_serial_en && !irq_par_en &&
    devctl_reg[2:1] == 2'h3)
    else $error("serialized mode decode wrong");

  a_id_mask_ones: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    diag_reg[`IRCFG_DG_IDMASK] |=> id_read_value == 32'hFFFFFFFF)
    else $error("identity not masked");

  a_id_true_pass: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !diag_reg[`IRCFG_DG_IDMASK] |=>
    id_read_value == $past(id_true_value))
    else $error("identity value altered");

  a_route_select: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    route_by_sel && chg_irq_sel != 4'h0 |-> !card_change_route)
    else $error("card change routed with nonzero select");

  a_async_irq: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    card_chg_event && card_change_route && !diag_reg[0] |=>
    !async_change_irq)
    else $error("async interrupt while disabled");

  a_retry_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    retry_limit == (diag_reg[3] ? 7'h40 : 7'h10))
    else $error("retry latency wrong");

  a_short_discard: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    dt_start[0] && dt_short_sel[0] ##1
    (!dt_start[0] && !dt_clear[0] && dt_short_sel[0])[*8]
    |-> dt_expired[0] == 1'b0)
    else $error("host discard timer expired early");

  a_test_tick: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    devctl_reg[3] && $past(devctl_reg[3]) |->
    interrog_cnt_reg < 17'(INTERROG_SHORT))
    else $error("short interrogation period not applied");

  c_id_masked: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && hit_diag && cfg_wdata[7] ##1 id_read_value == '1);
  c_power_blocked: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    sw_pwr_down_req && pwr_block);
  c_discard_expire: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    dt_expired[1]);
  c_async_irq: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    async_change_irq);

endmodule

// ### irq_mode_and_diag_config_tb_top.sv
`timescale 1ns/1ps
module irq_mode_and_diag_config_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int DLONG = 64;
  localparam int IFULL = 64;
  localparam int ISHORT = 16;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_func = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  // Arbitrary test pattern, stands for no real part
  logic [31:0] id_true_value = 32'h1234ABCD;
  logic [31:0] id_read_value;
  logic sw_pwr_down_req = 1'b0;
  logic in_d3 = 1'b0;
  logic socket_pwr_down, low_volt_socket_force, io_diag_flag;
  logic irq_par_en, irq_serial_en, irq_ser_pci_en, interrog_tick;
  logic nand_tree_en, nand_tree_out, card_change_route;
  logic [7:0] nand_pins = 8'hFF;
  logic chg_legacy_en = 1'b0;
  logic [3:0] chg_irq_sel = 4'h0;
  logic card_chg_event = 1'b0;
  logic async_change_irq, delayed_txn_off;
  logic [6:0] retry_limit;
  logic [1:0] dt_start = 2'h0;
  logic [1:0] dt_clear = 2'h0;
  logic [1:0] dt_expired;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [2:0] mode_exp [4] = '{3'h4, 3'h0, 3'h6, 3'h3};
  logic [7:0] r_diag [5] = '{8'h61, 8'h61, 8'h41, 8'h41, 8'h60};
  logic [3:0] r_sel [5] = '{4'h0, 4'h5, 4'h5, 4'h5, 4'h0};
  logic r_leg [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic r_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic r_route [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  ircfg_regs #(.NAND_PINS(8), .DISCARD_LONG(DLONG), .INTERROG_FULL(IFULL),
    .INTERROG_SHORT(ISHORT)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .id_true_value(id_true_value),
    .id_read_value(id_read_value), .sw_pwr_down_req(sw_pwr_down_req),
    .in_d3(in_d3), .socket_pwr_down(socket_pwr_down),
    .low_volt_socket_force(low_volt_socket_force),
    .io_diag_flag(io_diag_flag), .irq_par_en(irq_par_en),
    .irq_serial_en(irq_serial_en), .irq_ser_pci_en(irq_ser_pci_en),
    .interrog_tick(interrog_tick), .nand_tree_en(nand_tree_en),
    .nand_pins(nand_pins), .nand_tree_out(nand_tree_out),
    .chg_legacy_en(chg_legacy_en), .chg_irq_sel(chg_irq_sel),
    .card_chg_event(card_chg_event), .card_change_route(card_change_route),
    .async_change_irq(async_change_irq), .delayed_txn_off(delayed_txn_off),
    .retry_limit(retry_limit), .dt_start(dt_start), .dt_clear(dt_clear),
    .dt_expired(dt_expired));

  always #2.5 sys_clk = ~sys_clk;

  // Run is about 5500 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic summarize;
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle after each strobe keeps the pulse from merging
  task automatic wr(input logic f, input logic [7:0] a, input logic [7:0] d);
    cfg_func = f;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    tick();
    cfg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_func = 1'b0;
    cfg_addr = a;
    cfg_rd = 1'b1;
    tick();
    chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk("cfg_rdata", {24'h0, exp}, {24'h0, cfg_rdata});
    cfg_rd = 1'b0;
    tick();
    chk("cfg_rvalid_end", 32'h0, {31'h0, cfg_rvalid});
  endtask

  // Edges until pulse: 0/1 discard timers, 2 interrogation tick
  task automatic cnt_to(input int sel, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (hit !== 1'b1 && k < 3000) begin
      tick();
      k++;
      hit = (sel == 2) ? interrog_tick : dt_expired[sel];
    end
  endtask

  task automatic timer(input int sel, input int exp);
    dt_start[sel] = 1'b1;
    tick();
    dt_start[sel] = 1'b0;
    cnt_to(sel, n);
    chk("discard_edges", exp, n);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    tick();
    chk("low_volt", 32'h1, {31'h0, low_volt_socket_force});
    chk("io_diag", 32'h1, {31'h0, io_diag_flag});
    chk("retry", 32'h10, {25'h0, retry_limit});
    chk("id_read", id_true_value, id_read_value);
    rd(8'h92, 8'h66);
    rd(8'h93, 8'h61);
    rd(8'h91, 8'h00);
    wr(1'b0, 8'h92, 8'hFF);
    rd(8'h92, 8'hEF);
    wr(1'b1, 8'h92, 8'h00);
    rd(8'h92, 8'h4F);
    cnt_to(2, n);
    cnt_to(2, n);
    chk("interrog_short", ISHORT, n);
    wr(1'b0, 8'h92, 8'h00);
    cnt_to(2, n);
    cnt_to(2, n);
    chk("interrog_full", IFULL, n);
    for (int m = 0; m < 4; m++) begin
      wr(1'b0, 8'h92, {5'h00, m[1:0], 1'b0});
      chk("irq_mode", {29'h0, mode_exp[m]},
          {29'h0, irq_par_en, irq_serial_en, irq_ser_pci_en});
    end
    wr(1'b0, 8'h92, 8'h80);
    sw_pwr_down_req = 1'b1;
    in_d3 = 1'b1;
    repeat (2) tick();
    chk("pwr_down_d3", 32'h0, {31'h0, socket_pwr_down});
    in_d3 = 1'b0;
    repeat (2) tick();
    chk("pwr_down_d0", 32'h1, {31'h0, socket_pwr_down});
    sw_pwr_down_req = 1'b0;
    wr(1'b0, 8'h92, 8'h01);
    repeat (4) tick();
    chk("nand_ones", 32'h1, {31'h0, nand_tree_out});
    nand_pins = 8'hFE;
    repeat (4) tick();
    chk("nand_zero", 32'h0, {31'h0, nand_tree_out});
    wr(1'b0, 8'h92, 8'h00);
    repeat (2) tick();
    chk("nand_off", 32'h0, {30'h0, nand_tree_en, nand_tree_out});
    wr(1'b0, 8'h93, 8'h80);
    tick();
    chk("id_mask", 32'hFFFFFFFF, id_read_value);
    rd(8'h93, 8'h80);
    wr(1'b0, 8'h93, 8'h1A);
    tick();
    chk("id_true", id_true_value, id_read_value);
    chk("no_dt", 32'h1, {31'h0, delayed_txn_off});
    chk("retry_long", 32'h40, {25'h0, retry_limit});
    timer(0, 1024);
    timer(1, DLONG);
    wr(1'b0, 8'h93, 8'h04);
    chk("dt_on", 32'h0, {31'h0, delayed_txn_off});
    timer(0, DLONG);
    timer(1, 1024);
    dt_start[0] = 1'b1;
    tick();
    dt_start[0] = 1'b0;
    repeat (8) tick();
    dt_clear[0] = 1'b1;
    tick();
    dt_clear[0] = 1'b0;
    cnt_to(0, n);
    chk("discard_cleared", 3000, n);
    for (int i = 0; i < 5; i++) begin
      wr(1'b0, 8'h93, r_diag[i]);
      chg_irq_sel = r_sel[i];
      chg_legacy_en = r_leg[i];
      card_chg_event = 1'b1;
      tick();
      card_chg_event = 1'b0;
      chk("async_irq", {31'h0, r_exp[i]},
          {31'h0, async_change_irq});
      chk("route", {31'h0, r_route[i]},
          {31'h0, card_change_route});
      tick();
    end
    summarize();
  end
endmodule
